//--- rtl/rcp_consts.svh
`ifndef RCP_CONSTS_SVH
`define RCP_CONSTS_SVH

// register byte addresses, 12-bit window
`define RCP_ADDR_POWER 12'hF80
`define RCP_ADDR_CAUSE 12'hFF0

// power disable register: reset value and implemented bits
`define RCP_POWER_RESET 8'h88
`define RCP_POWER_COMP_BIT 1
`define RCP_POWER_BROWNOUT_BIT 4

// cause flags as one nibble: power_on, sleep_recovery, watchdog_expiry, pin_reset
`define RCP_CAUSE_POWER_ON 4'h8
`define RCP_CAUSE_PIN_RESET 4'h1
`define RCP_CAUSE_WDT_RESET 4'h2
`define RCP_CAUSE_PIN_WAKE 4'h4
`define RCP_CAUSE_LSB 4

// bus responses
`define RCP_RESP_OKAY 2'h0
`define RCP_RESP_SLVERR 2'h2

`endif

//--- rtl/rcp_pkg.sv
package rcp_pkg;

  // power state of the device
  typedef enum logic [1:0] {
    RCP_RUN = 2'b00,
    RCP_HALT = 2'b01,
    RCP_SLEEP = 2'b10
  } rcp_mode_t;

  // register select from address decode
  typedef enum logic [1:0] {
    RCP_SEL_NONE = 2'b00,
    RCP_SEL_POWER = 2'b01,
    RCP_SEL_CAUSE = 2'b10
  } rcp_sel_t;

  // cause flags, msb first as in the status byte
  typedef struct packed {
    logic power_on_flag;
    logic sleep_recovery_flag;
    logic watchdog_expiry_flag;
    logic pin_reset_flag;
  } rcp_cause_t;

  // one-cycle register strobes from the bus slave
  typedef struct packed {
    logic wr;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic rd;
    logic [11:0] rd_addr;
  } rcp_req_t;

endpackage : rcp_pkg

//--- rtl/rcp_axil_slave.sv
`include "rcp_consts.svh"

module rcp_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output rcp_pkg::rcp_req_t req,
  input wire logic [31:0] rd_data,
  input wire logic rd_err,
  input wire logic wr_err
);

  logic aw_held; // address captured, waiting for data
  logic w_held; // data captured, waiting for address
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_fire;

  // write issues once both halves are in and no response is pending
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  // read issues on the address handshake itself
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    req.wr = wr_fire;
    req.wr_addr = aw_addr;
    req.wr_data = w_data;
    req.wr_strb = w_strb;
    req.rd = rd_fire;
    req.rd_addr = s_axi_araddr;
  end

  // write address channel, one outstanding write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      if (wr_fire) aw_held <= 1'b0;
      // reopen only once the response has gone
      if (s_axi_bvalid && s_axi_bready) s_axi_awready <= 1'b1;
    end
  end

  // write data channel, taken in either order against the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      if (wr_fire) w_held <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) s_axi_wready <= 1'b1;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RCP_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? `RCP_RESP_SLVERR : `RCP_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: data sampled at the handshake edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RCP_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? `RCP_RESP_SLVERR : `RCP_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : rcp_axil_slave

//--- rtl/rcp_top.sv
// Our own choice: register access over AXI4-Lite.
`include "rcp_consts.svh"

module rcp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ev_pin_reset,
  input wire logic ev_wdt_expiry,
  input wire logic wdt_reset_mode,
  input wire logic ev_pin_change,
  input wire logic ev_debugger_reset,
  input wire logic debug_line_low,
  input wire logic ev_brownout_reset,
  input wire logic irq_pending,
  input wire logic sleep_instr,
  input wire logic halt_instr,
  input wire logic wdt_enable,
  input wire logic crystal_enable,
  input wire logic brownout_always_on_option,
  output rcp_pkg::rcp_mode_t power_mode,
  output logic main_osc_enable,
  output logic sys_clk_enable,
  output logic cpu_run,
  output logic periph_idle,
  output logic wdt_osc_enable,
  output logic brownout_run,
  output logic brownout_disable,
  output logic crystal_pins_owned,
  output logic comparator_disable,
  output logic comparator_clk_enable,
  output logic [7:0] wdt_ctrl_data,
  output logic wdt_ctrl_write
);

  // all event and instruction inputs come from logic on aclk, so no synchronisers

  rcp_pkg::rcp_req_t req; // bus strobes, one cycle each
  rcp_pkg::rcp_cause_t cause; // sticky cause flags
  rcp_pkg::rcp_cause_t next_cause;
  rcp_pkg::rcp_mode_t next_mode;
  rcp_pkg::rcp_sel_t rd_sel;
  rcp_pkg::rcp_sel_t wr_sel;
  logic [7:0] power; // peripheral_power_disable contents
  logic [7:0] next_power;
  logic [31:0] rd_data;
  logic sleeping; // current mode is deep sleep
  logic dbg_reset; // debugger reset of either kind
  logic wdt_sys_reset; // watchdog expiry that resets the system
  logic any_reset; // any non power-on system reset

  // address decode shared by the read and write paths
  function automatic rcp_pkg::rcp_sel_t rcp_decode(input logic [11:0] addr);
    if (addr == `RCP_ADDR_POWER) begin
      return rcp_pkg::RCP_SEL_POWER;
    end else if (addr == `RCP_ADDR_CAUSE) begin
      return rcp_pkg::RCP_SEL_CAUSE;
    end else begin
      return rcp_pkg::RCP_SEL_NONE;
    end
  endfunction : rcp_decode

  rcp_axil_slave rcp_axil_slave_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .req(req),
    .rd_data(rd_data),
    .rd_err(rd_sel == rcp_pkg::RCP_SEL_NONE),
    .wr_err(wr_sel == rcp_pkg::RCP_SEL_NONE)
  );

  assign rd_sel = rcp_decode(req.rd_addr);
  assign wr_sel = rcp_decode(req.wr_addr);
  assign sleeping = (power_mode == rcp_pkg::RCP_SLEEP);
  // debug line only resets from deep sleep
  assign dbg_reset = ev_debugger_reset || (debug_line_low && sleeping);
  assign wdt_sys_reset = ev_wdt_expiry && wdt_reset_mode && !sleeping;
  assign any_reset = ev_pin_reset || dbg_reset || ev_brownout_reset || wdt_sys_reset;

  // read mux; the watchdog control half of the shared address is write-only
  always_comb begin
    case (rd_sel)
      rcp_pkg::RCP_SEL_POWER: rd_data = {24'h00_0000, power};
      rcp_pkg::RCP_SEL_CAUSE: rd_data = {24'h00_0000, cause, 4'h0};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // cause flags; later lines win, so an event beats a same-cycle read clear
  always_comb begin
    next_cause = cause;
    if (req.rd && rd_sel == rcp_pkg::RCP_SEL_CAUSE) begin
      next_cause = 4'h0;
    end
    if (ev_pin_change && sleeping) begin
      next_cause = `RCP_CAUSE_PIN_WAKE;
    end
    if (ev_wdt_expiry) begin
      if (sleeping) begin
        // recovery by watchdog keeps the pin reset flag as it stands
        next_cause = {1'b0, 1'b1, 1'b1, next_cause.pin_reset_flag};
      end else if (wdt_reset_mode) begin
        next_cause = `RCP_CAUSE_WDT_RESET;
      end else begin
        next_cause = {1'b0, 1'b0, 1'b1, next_cause.pin_reset_flag};
      end
    end
    if (dbg_reset) begin
      next_cause = `RCP_CAUSE_POWER_ON;
    end
    if (ev_pin_reset) begin
      next_cause = `RCP_CAUSE_PIN_RESET;
    end
  end

  // aresetn is the power-on reset: flags start as power-on only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause <= `RCP_CAUSE_POWER_ON;
    end else begin
      cause <= next_cause;
    end
  end

  // power register; other system resets arrive as events and leave it alone
  always_comb begin
    next_power = power;
    if (req.wr && wr_sel == rcp_pkg::RCP_SEL_POWER && req.wr_strb[0]) begin
      // reserved bits are stored as written; software keeps them zero
      next_power = req.wr_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power <= `RCP_POWER_RESET;
    end else begin
      power <= next_power;
    end
  end

  // writes to the shared address go out to the watchdog
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_ctrl_data <= 8'h00;
      wdt_ctrl_write <= 1'b0;
    end else begin
      wdt_ctrl_write <= req.wr && wr_sel == rcp_pkg::RCP_SEL_CAUSE && req.wr_strb[0];
      if (req.wr && wr_sel == rcp_pkg::RCP_SEL_CAUSE && req.wr_strb[0]) begin
        wdt_ctrl_data <= req.wr_data[7:0];
      end
    end
  end

  // mode sequencing
  always_comb begin
    case (power_mode)
      rcp_pkg::RCP_RUN: begin
        if (any_reset) begin
          next_mode = rcp_pkg::RCP_RUN;
        end else if (sleep_instr) begin
          next_mode = rcp_pkg::RCP_SLEEP;
        end else if (halt_instr) begin
          next_mode = rcp_pkg::RCP_HALT;
        end else begin
          next_mode = rcp_pkg::RCP_RUN;
        end
      end
      rcp_pkg::RCP_HALT: begin
        // a pending interrupt or any watchdog expiry wakes the core
        if (irq_pending || ev_wdt_expiry || any_reset) begin
          next_mode = rcp_pkg::RCP_RUN;
        end else begin
          next_mode = rcp_pkg::RCP_HALT;
        end
      end
      rcp_pkg::RCP_SLEEP: begin
        if (ev_pin_change || ev_wdt_expiry || ev_pin_reset || dbg_reset) begin
          next_mode = rcp_pkg::RCP_RUN;
        end else begin
          next_mode = rcp_pkg::RCP_SLEEP;
        end
      end
      default: next_mode = rcp_pkg::RCP_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_mode <= rcp_pkg::RCP_RUN;
    end else begin
      power_mode <= next_mode;
    end
  end

  // clock and core controls follow the next mode so they change with it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_osc_enable <= 1'b1;
      sys_clk_enable <= 1'b1;
      cpu_run <= 1'b1;
      periph_idle <= 1'b0;
    end else begin
      main_osc_enable <= next_mode != rcp_pkg::RCP_SLEEP;
      sys_clk_enable <= next_mode != rcp_pkg::RCP_SLEEP;
      cpu_run <= next_mode == rcp_pkg::RCP_RUN;
      periph_idle <= next_mode == rcp_pkg::RCP_SLEEP;
    end
  end

  // watchdog, brownout and crystal pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_osc_enable <= 1'b0;
      brownout_run <= 1'b1;
      crystal_pins_owned <= 1'b0;
    end else begin
      wdt_osc_enable <= wdt_enable;
      // in sleep only the nonvolatile option keeps the monitor alive
      brownout_run <= (next_mode == rcp_pkg::RCP_SLEEP) ? brownout_always_on_option
                      : !next_power[`RCP_POWER_BROWNOUT_BIT];
      crystal_pins_owned <= crystal_enable && next_mode != rcp_pkg::RCP_SLEEP;
    end
  end

  // per-peripheral disables from the power register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // bit 1 of the power reset value is clear, so the comparator starts enabled
      comparator_disable <= 1'b0;
      comparator_clk_enable <= 1'b1;
      brownout_disable <= 1'b0;
    end else begin
      comparator_disable <= next_power[`RCP_POWER_COMP_BIT];
      // gate the comparator clock when disabled or when peripherals idle
      comparator_clk_enable <= !next_power[`RCP_POWER_COMP_BIT]
                               && next_mode != rcp_pkg::RCP_SLEEP;
      brownout_disable <= next_power[`RCP_POWER_BROWNOUT_BIT];
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic quiet; // no event besides the one under test
  assign quiet = !ev_pin_reset && !dbg_reset && !ev_wdt_expiry && !ev_pin_change;

  a_wdt_clears_por: assert property (ev_wdt_expiry && !ev_pin_reset && !dbg_reset
    |=> !cause.power_on_flag && cause.watchdog_expiry_flag)
    else $error("watchdog expiry left power-on flag or missed watchdog flag");
  a_read_clears: assert property (req.rd && rd_sel == rcp_pkg::RCP_SEL_CAUSE && quiet
    |=> cause == 4'h0)
    else $error("cause read did not clear flags");
  a_pin_wake_flags: assert property (ev_pin_change && sleeping && !ev_pin_reset
    && !dbg_reset && !ev_wdt_expiry |=> cause == 4'h4 && power_mode == rcp_pkg::RCP_RUN)
    else $error("pin wake flags or mode wrong");
  a_wdt_wake_flags: assert property (ev_wdt_expiry && sleeping && !ev_pin_reset && !dbg_reset
    |=> cause.sleep_recovery_flag && cause.watchdog_expiry_flag)
    else $error("watchdog wake flags wrong");
  a_pin_reset_pat: assert property (ev_pin_reset |=> cause == 4'h1)
    else $error("pin reset pattern wrong");
  a_debug_reset_pat: assert property (dbg_reset && !ev_pin_reset |=> cause == 4'h8)
    else $error("debugger reset pattern wrong");
  a_sleep_stops_all: assert property (sleeping |-> !sys_clk_enable && !main_osc_enable
    && !cpu_run && periph_idle && !crystal_pins_owned)
    else $error("sleep left clocks, core or crystal running");
  a_sleep_brownout: assert property (sleeping |-> brownout_run == $past(brownout_always_on_option))
    else $error("brownout monitor state in sleep wrong");
  a_halt_clocks_on: assert property (power_mode == rcp_pkg::RCP_HALT |-> sys_clk_enable && !cpu_run)
    else $error("halt stopped clock or left core running");
  a_halt_wakeup: assert property (power_mode == rcp_pkg::RCP_HALT && irq_pending |=> cpu_run)
    else $error("interrupt did not end halt");
  a_power_holds: assert property (!(req.wr && wr_sel == rcp_pkg::RCP_SEL_POWER) |=> $stable(power))
    else $error("power register changed without a write");
  // checks the write path end to end, not just the register copy
  a_comp_follows: assert property (req.wr && wr_sel == rcp_pkg::RCP_SEL_POWER && req.wr_strb[0]
    |=> comparator_disable == $past(req.wr_data[1]))
    else $error("comparator disable differs from written bit");
  // only cause reads: the power register may hold ones in its low nibble
  a_reserved_zero: assert property (req.rd && rd_sel == rcp_pkg::RCP_SEL_CAUSE
    |=> s_axi_rvalid && s_axi_rdata[3:0] == 4'h0)
    else $error("reserved cause bits read nonzero");

  c_pin_wake: cover property (sleeping ##1 ev_pin_change ##1 cpu_run);
  c_halt_irq: cover property (power_mode == rcp_pkg::RCP_HALT && irq_pending);
  c_read_por: cover property (req.rd && rd_sel == rcp_pkg::RCP_SEL_CAUSE && cause.power_on_flag);
  c_set_beats_clear: cover property (req.rd && rd_sel == rcp_pkg::RCP_SEL_CAUSE && ev_wdt_expiry);

endmodule : rcp_top

//--- dv/rcp_tb.sv
`include "rcp_consts.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // one table row: enter sleep first, event index, watchdog reset mode, status byte expected
  typedef struct packed {
    logic slp;
    logic [3:0] ev;
    logic rst_mode;
    logic [7:0] exp;
  } rcp_row_t;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // event bits: pin reset, wdt, pin change, debugger, brownout, sleep, halt, debug line, irq
  logic [8:0] ev = 9'h000;
  logic wmode = 1'b0; // watchdog expiry resets when high
  logic bopt = 1'b0; // brownout kept alive in sleep
  logic wen = 1'b1; // watchdog oscillator enable
  logic xen = 1'b1; // crystal oscillator enable
  rcp_pkg::rcp_mode_t power_mode;
  logic main_osc, sys_clk, cpu_run, idle, wdt_osc, bo_run, bo_dis, xtal, cmp_dis, cmp_clk;
  logic [7:0] ctrl_data;
  logic ctrl_wr;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  int wr_seen = 0;
  logic [7:0] last_ctrl = 8'h00;
  // grouped mode outputs so one compare covers a whole power state
  wire [5:0] mbits = {main_osc, sys_clk, cpu_run, idle, xtal, cmp_clk};
  rcp_row_t rows [8] = '{{1'b0, 4'd0, 1'b0, 8'h10}, {1'b0, 4'd3, 1'b0, 8'h80},
    {1'b0, 4'd1, 1'b1, 8'h20}, {1'b0, 4'd1, 1'b0, 8'h20}, {1'b1, 4'd2, 1'b0, 8'h40},
    {1'b1, 4'd1, 1'b0, 8'h60}, {1'b1, 4'd7, 1'b0, 8'h80}, {1'b0, 4'd4, 1'b0, 8'h00}};
  int hw [5] = '{8, 1, 0, 4, 3}; // halt wake sources
  logic [7:0] hx [5] = '{8'h00, 8'h20, 8'h10, 8'h00, 8'h80};

  // 125 MHz clock
  always #4 aclk = ~aclk;

  rcp_top rcp_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ev_pin_reset(ev[0]),
    .ev_wdt_expiry(ev[1]), .wdt_reset_mode(wmode), .ev_pin_change(ev[2]), .ev_debugger_reset(ev[3]),
    .debug_line_low(ev[7]), .ev_brownout_reset(ev[4]), .irq_pending(ev[8]), .sleep_instr(ev[5]),
    .halt_instr(ev[6]), .wdt_enable(wen), .crystal_enable(xen), .brownout_always_on_option(bopt),
    .power_mode(power_mode), .main_osc_enable(main_osc), .sys_clk_enable(sys_clk), .cpu_run(cpu_run),
    .periph_idle(idle), .wdt_osc_enable(wdt_osc), .brownout_run(bo_run), .brownout_disable(bo_dis),
    .crystal_pins_owned(xtal), .comparator_disable(cmp_dis), .comparator_clk_enable(cmp_clk),
    .wdt_ctrl_data(ctrl_data), .wdt_ctrl_write(ctrl_wr));

  // count watchdog control strobes, a one-cycle pulse is easy to miss otherwise
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (ctrl_wr === 1'b1) begin
      wr_seen <= wr_seen + 1;
      last_ctrl <= ctrl_data;
    end
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // write one byte, hold each channel until its own handshake
  task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // no cycle limit here: only the bench timeout ends a wait
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask : axw

  // read one word and compare data and response
  task automatic axr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, {24'h0, d});
    check({30'h0, rresp}, {30'h0, er});
  endtask : axr

  // one-cycle event, then let the sampling edge land
  task automatic pulse(input int i);
    @(posedge aclk);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev[i] <= 1'b0;
    #1;
  endtask : pulse

  task automatic complete_run();
    $display("comparisons=%0d miscompares=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // power-on values
    axr(`RCP_ADDR_POWER, 8'h88, `RCP_RESP_OKAY);
    axr(`RCP_ADDR_CAUSE, 8'h80, `RCP_RESP_OKAY);
    axr(`RCP_ADDR_CAUSE, 8'h00, `RCP_RESP_OKAY);
    // table of single events, each read twice so the clear shows
    foreach (rows[i]) begin
      @(posedge aclk);
      wmode <= rows[i].rst_mode;
      if (rows[i].slp) begin
        pulse(5);
        check({30'h0, power_mode}, {30'h0, rcp_pkg::RCP_SLEEP});
        check({26'h0, mbits, bo_run, wdt_osc}, {26'h0, 6'b000100, 1'b0, 1'b1});
      end
      pulse(rows[i].ev);
      check({30'h0, power_mode}, {30'h0, rcp_pkg::RCP_RUN});
      axr(`RCP_ADDR_CAUSE, rows[i].exp, `RCP_RESP_OKAY);
      axr(`RCP_ADDR_CAUSE, 8'h00, `RCP_RESP_OKAY);
    end
    // pin flag survives an interrupt-mode expiry, cleared by a pin-change wake
    pulse(0);
    pulse(1);
    axr(`RCP_ADDR_CAUSE, 8'h30, `RCP_RESP_OKAY);
    pulse(0);
    pulse(5);
    pulse(2);
    axr(`RCP_ADDR_CAUSE, 8'h40, `RCP_RESP_OKAY);
    // sleep flag dropped by a reset-mode expiry outside sleep
    pulse(5);
    pulse(2);
    @(posedge aclk);
    wmode <= 1'b1;
    pulse(1);
    axr(`RCP_ADDR_CAUSE, 8'h20, `RCP_RESP_OKAY);
    // brownout kept by option, and a brownout does not end sleep
    @(posedge aclk);
    bopt <= 1'b1;
    pulse(5);
    pulse(4);
    check({29'h0, power_mode, bo_run}, {29'h0, rcp_pkg::RCP_SLEEP, 1'b1});
    pulse(2);
    axr(`RCP_ADDR_CAUSE, 8'h40, `RCP_RESP_OKAY);
    // halt and each way out of it
    @(posedge aclk);
    wmode <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      pulse(6);
      check({26'h0, mbits}, {26'h0, 6'b110011});
      check({30'h0, power_mode}, {30'h0, rcp_pkg::RCP_HALT});
      pulse(hw[k]);
      check({30'h0, power_mode}, {30'h0, rcp_pkg::RCP_RUN});
      axr(`RCP_ADDR_CAUSE, hx[k], `RCP_RESP_OKAY);
    end
    // power bits; software keeps reserved bits zero
    axw(`RCP_ADDR_POWER, 8'h02, 4'hF, `RCP_RESP_OKAY);
    check({30'h0, cmp_dis, cmp_clk}, 32'h2);
    axw(`RCP_ADDR_POWER, 8'h10, 4'hF, `RCP_RESP_OKAY);
    check({29'h0, bo_dis, bo_run, cmp_clk}, 32'h5);
    axw(`RCP_ADDR_POWER, 8'h02, 4'h0, `RCP_RESP_OKAY);
    axr(`RCP_ADDR_POWER, 8'h10, `RCP_RESP_OKAY);
    // a pin reset leaves the power register alone
    pulse(0);
    axr(`RCP_ADDR_POWER, 8'h10, `RCP_RESP_OKAY);
    axr(`RCP_ADDR_CAUSE, 8'h10, `RCP_RESP_OKAY);
    // shared address: writes go to the watchdog, status untouched
    axw(`RCP_ADDR_CAUSE, 8'h5A, 4'hF, `RCP_RESP_OKAY);
    @(posedge aclk);
    check(wr_seen, 1);
    check({24'h0, last_ctrl}, 32'h5A);
    axr(`RCP_ADDR_CAUSE, 8'h00, `RCP_RESP_OKAY);
    // unmapped place answers with an error
    axw(12'h004, 8'hFF, 4'hF, `RCP_RESP_SLVERR);
    axr(12'h004, 8'h00, `RCP_RESP_SLVERR);
    // oscillator enables off: watchdog oscillator and crystal pins follow them
    @(posedge aclk);
    wen <= 1'b0;
    xen <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
    check({30'h0, wdt_osc, xtal}, 32'h0);
    @(posedge aclk);
    wen <= 1'b1;
    xen <= 1'b1;
    // second power-on in mid-run restores both registers
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(`RCP_ADDR_POWER, 8'h88, `RCP_RESP_OKAY);
    axr(`RCP_ADDR_CAUSE, 8'h80, `RCP_RESP_OKAY);
    complete_run();
  end

endmodule : tb
